/* File: core/nvm_defines.svh */
// Register offsets, field positions, reset values and keys of the
// stored-configuration control block.
// Assumes a byte-wide register address and 16-bit register data.
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH

// ======================================================================
// Register offsets
`define NVM_ADDR_KEY        8'h31
`define NVM_ADDR_STATUS     8'h32
`define NVM_ADDR_LOCATION   8'h33
`define NVM_ADDR_WDATA      8'h34
`define NVM_ADDR_ACCESS     8'h35
`define NVM_ADDR_RDATA      8'h36
`define NVM_ADDR_HALT       8'h60
`define NVM_ADDR_CFG_BASE   8'h90

// ======================================================================
// Field positions
`define NVM_BIT_SHADOW      12
`define NVM_BIT_RELOAD      8
`define NVM_BIT_WEN         2
`define NVM_MODE_HI         1
`define NVM_MODE_LO         0
`define NVM_BIT_READY       0
`define NVM_BIT_HALT        15
`define NVM_SSM_HI          15
`define NVM_SSM_LO          14
`define NVM_TOL_HI          13
`define NVM_TOL_LO          12
`define NVM_DIV_HI          11
`define NVM_DIV_LO          8
`define NVM_BIT_CYCADJ      7
`define NVM_SHIFT_HI        6
`define NVM_SHIFT_LO        4
`define NVM_MANT_HI         3
`define NVM_MANT_LO         0

// ======================================================================
// Values
`define NVM_UNLOCK_VALUE    16'hc0de
`define NVM_RESET_WORD      16'h0000
`define NVM_TOL_ALWAYS      2'h0
`define NVM_TOL_CLOSED      2'h1
`define NVM_TOL_FIRST_OPEN  2'h2

`endif

/* File: core/nvm_pkg.sv */
// Types shared by the stored-configuration control block.
// Assumes the defines header is compiled alongside.
package nvm_pkg;

  // Sequencer states of the stored-word engine.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RELOAD,
    ST_PROGRAM,
    ST_WAIT
  } seq_state_t;

  // Access mode field codes.
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_MASS = 2'h2,
    MODE_BAD = 2'h3
  } access_mode_t;

endpackage : nvm_pkg

/* File: core/nvm_cell_array.sv */
// Nonvolatile word array holding the stored configuration words.
// Assumes one write at a time; the owner waits for busy to fall.
`timescale 1ns/100ps
`include "nvm_defines.svh"

module nvm_cell_array #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 7,
  parameter int IDX_W = 3,
  parameter int WRITE_CYCLES = 8
) (
  input wire logic core_clk, // Device clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ce, // Clock enable; freezes all state while low.
  input wire logic wr_en, // Write strobe for one word.
  input wire logic [IDX_W-1:0] wr_idx, // Word index to write.
  input wire logic [DATA_W-1:0] wr_data, // Word to write.
  input wire logic [IDX_W-1:0] rd_idx, // Word index to read.
  output logic [DATA_W-1:0] rd_data, // Combinational read data.
  output logic busy // High while a write is in progress.
);

  // ====================================================================
  // Storage
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DEPTH-1:0] written;
  logic [7:0] busy_cnt;

  // The cells hold no reset; a written mask makes untouched words read
  // as the reset word so nothing unknown leaks out after power-up.
  always_ff @(posedge core_clk)
  begin
    if (ce && wr_en)
      mem[wr_idx] <= wr_data;
  end

  // Track which words have ever been programmed.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      written <= '0;
    else if (ce && wr_en)
      written[wr_idx] <= 1'b1;
  end

  // Program time counter; the cell timing is a stand-in figure.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_cnt <= 8'h00;
    else if (ce)
    begin
      if (wr_en)
        busy_cnt <= 8'(WRITE_CYCLES);
      else if (busy_cnt != 8'h00)
        busy_cnt <= busy_cnt - 8'h01;
    end
  end

  // Read port and busy flag.
  assign rd_data = written[rd_idx] ? mem[rd_idx] : `NVM_RESET_WORD;
  assign busy = (busy_cnt != 8'h00);

endmodule : nvm_cell_array

/* File: core/nvm_shadow_config_regs.sv */
// Register file and sequencer for stored configuration words with
// shadow copies, plus decode of the first configuration word.
// Assumes an external serial front end turns bus transfers into the
// single-cycle register strobes below, synchronous to core_clk.
//
// Summary of operation
// - Shadow select chooses shadow values and readback.
// - Reload copies stored words into shadows.
// - Mode: off, single word, mass; 11 forbidden.
// - Read data holds last single-read word.
// - Unused addresses: no storage, no effects.
// - Halt bit stops motor without sleeping.
// - Halt bit is write-only, reads zero.
// - Spread spectrum select: none, 5, 10, 15.
// - Tach gating by loop state select.
// - Tach frequency is speed over n+1.
// - Cycle adjust: full when 0, half 1.
// - Resistance is mantissa shifted by shift.
// - Location register selects single-access word.
// - Write data register feeds single-word write.
// - Ready bit reports store free for access.
`timescale 1ns/100ps
`include "nvm_defines.svh"

module nvm_shadow_config_regs #(
  parameter int DEPTH = 7,
  parameter int IDX_W = 3,
  parameter int WRITE_CYCLES = 8
) (
  input wire logic core_clk, // Device clock, 200 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ce, // Clock enable.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic reg_rd, // Read strobe, one cycle.
  output logic [15:0] reg_rdata, // Read data, valid after reg_rd.
  input wire logic elec_tick, // One pulse per electrical half-cycle.
  input wire logic closed_loop, // Motor runs in closed loop.
  input wire logic first_open_loop, // Motor is in its first open loop.
  output logic tach_out, // Tach output.
  output logic motor_halt, // Motor control disabled.
  output logic [1:0] spread_spectrum_sel, // Dither select.
  output logic cycle_adjust_sel, // 0 full-cycle, 1 half-cycle.
  output logic [10:0] phase_resistance, // Mantissa shifted by shift.
  output logic nvm_ready // Store ready for access.
);

  // ====================================================================
  // Declarations
  nvm_pkg::seq_state_t state;
  nvm_pkg::access_mode_t mode;
  logic [15:0] unlock_key;
  logic [7:0] single_access_location;
  logic [15:0] single_write_value;
  logic [15:0] single_read_value;
  logic shadow_select;
  logic nvm_reload;
  logic nvm_write_enable;
  logic [15:0] shadow [DEPTH];
  logic [15:0] stored_cfg;
  logic [IDX_W-1:0] seq_idx;
  logic seq_mass;
  logic [15:0] active_cfg;
  logic granted;
  logic [7:0] loc_off;
  logic loc_ok;
  logic [IDX_W-1:0] loc_idx;
  logic acc_wr;
  logic st_wr;
  logic [IDX_W-1:0] st_wr_idx;
  logic [15:0] st_wr_data;
  logic [IDX_W-1:0] st_rd_idx;
  logic [15:0] st_rd_data;
  logic st_busy;
  logic [3:0] tach_cnt;
  logic tach_phase;
  logic tach_gate;
  logic [15:0] next_rdata;

  // ====================================================================
  // Store
  nvm_cell_array #(
    .DATA_W(16),
    .DEPTH(DEPTH),
    .IDX_W(IDX_W),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_cells (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(st_wr),
    .wr_idx(st_wr_idx),
    .wr_data(st_wr_data),
    .rd_idx(st_rd_idx),
    .rd_data(st_rd_data),
    .busy(st_busy)
  );

  // ====================================================================
  // Access decode
  // key and mode gate
  assign granted = (unlock_key == `NVM_UNLOCK_VALUE) &&
                   (mode == nvm_pkg::MODE_SINGLE || mode == nvm_pkg::MODE_MASS);
  assign loc_off = single_access_location - `NVM_ADDR_CFG_BASE;
  assign loc_ok = (single_access_location >= `NVM_ADDR_CFG_BASE) && (loc_off < 8'(DEPTH));
  assign loc_idx = loc_off[IDX_W-1:0];
  assign acc_wr = reg_wr && (reg_addr == `NVM_ADDR_ACCESS);

  // Store port drive; the read index follows the sequencer during reload only.
  assign st_wr = ce && (state == nvm_pkg::ST_PROGRAM) && !st_busy;
  assign st_wr_idx = seq_idx;
  assign st_wr_data = seq_mass ? shadow[seq_idx] : single_write_value;
  assign st_rd_idx = (state == nvm_pkg::ST_RELOAD) ? seq_idx : loc_idx;

  // shadow or stored word drives the device
  assign active_cfg = shadow_select ? shadow[0] : stored_cfg;

  // ====================================================================
  // Host-written control registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      unlock_key <= `NVM_RESET_WORD;
      single_access_location <= 8'h00;
      single_write_value <= `NVM_RESET_WORD;
      shadow_select <= 1'b0;
      mode <= nvm_pkg::MODE_OFF;
      motor_halt <= 1'b0;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == `NVM_ADDR_KEY)
        unlock_key <= reg_wdata;
      else if (reg_addr == `NVM_ADDR_LOCATION)
        single_access_location <= reg_wdata[7:0];
      else if (reg_addr == `NVM_ADDR_WDATA)
        single_write_value <= reg_wdata;
      else if (reg_addr == `NVM_ADDR_ACCESS)
      begin
        shadow_select <= reg_wdata[`NVM_BIT_SHADOW];
        mode <= nvm_pkg::access_mode_t'(reg_wdata[`NVM_MODE_HI:`NVM_MODE_LO]);
      end
      else if (reg_addr == `NVM_ADDR_HALT)
        motor_halt <= reg_wdata[`NVM_BIT_HALT];
    end
  end

  // ====================================================================
  // Sequencer: reload, single and mass programming
  // The trigger bits read back as 1 until their operation ends, so
  // software can poll either them or the ready bit.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= nvm_pkg::ST_IDLE;
      seq_idx <= '0;
      seq_mass <= 1'b0;
      nvm_reload <= 1'b0;
      nvm_write_enable <= 1'b0;
    end
    else if (ce)
    begin
      case (state)
        nvm_pkg::ST_IDLE:
        begin
          // reload wins over a write request
          if (acc_wr && granted && !st_busy && reg_wdata[`NVM_BIT_RELOAD])
          begin
            nvm_reload <= 1'b1;
            seq_idx <= '0;
            state <= nvm_pkg::ST_RELOAD;
          end
          else if (acc_wr && granted && !st_busy && reg_wdata[`NVM_BIT_WEN])
          begin
            if (reg_wdata[`NVM_MODE_HI:`NVM_MODE_LO] == nvm_pkg::MODE_MASS)
            begin
              nvm_write_enable <= 1'b1;
              seq_mass <= 1'b1;
              seq_idx <= '0;
              state <= nvm_pkg::ST_PROGRAM;
            end
            else if (loc_ok && mode == nvm_pkg::MODE_SINGLE)
            begin
              nvm_write_enable <= 1'b1;
              seq_mass <= 1'b0;
              seq_idx <= loc_idx;
              state <= nvm_pkg::ST_PROGRAM;
            end
          end
        end
        nvm_pkg::ST_RELOAD:
        begin
          if (seq_idx == IDX_W'(DEPTH - 1))
          begin
            nvm_reload <= 1'b0;
            state <= nvm_pkg::ST_IDLE;
          end
          else
            seq_idx <= seq_idx + 1'b1;
        end
        nvm_pkg::ST_PROGRAM:
        begin
          if (!st_busy)
            state <= nvm_pkg::ST_WAIT;
        end
        nvm_pkg::ST_WAIT:
        begin
          if (!st_busy)
          begin
            if (seq_mass && seq_idx != IDX_W'(DEPTH - 1))
            begin
              seq_idx <= seq_idx + 1'b1;
              state <= nvm_pkg::ST_PROGRAM;
            end
            else
            begin
              nvm_write_enable <= 1'b0;
              state <= nvm_pkg::ST_IDLE;
            end
          end
        end
        default:
          state <= nvm_pkg::ST_IDLE;
      endcase
    end
  end

  // ====================================================================
  // Shadow words: host writes to the word window, reload fills them.
  // Only the first word is decoded here; the rest are kept for mass
  // programming and are not read back.
  for (genvar gi = 0; gi < DEPTH; gi++)
  begin : g_shadow
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        shadow[gi] <= `NVM_RESET_WORD;
      else if (ce)
      begin
        if (state == nvm_pkg::ST_RELOAD && seq_idx == IDX_W'(gi))
          shadow[gi] <= st_rd_data;
        else if (reg_wr && reg_addr == `NVM_ADDR_CFG_BASE + 8'(gi))
          shadow[gi] <= reg_wdata;
      end
    end
  end

  // Mirror of the first stored word, kept in step with programming.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      stored_cfg <= `NVM_RESET_WORD;
    else if (ce && st_wr && st_wr_idx == '0)
      stored_cfg <= st_wr_data;
  end

  // single read captures selected word
  // A read is taken on every idle, unlocked single-mode cycle with a valid location, no cell write running and no register write.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      single_read_value <= `NVM_RESET_WORD;
    else if (ce && state == nvm_pkg::ST_IDLE && !st_busy && loc_ok && granted &&
             mode == nvm_pkg::MODE_SINGLE && !reg_wr)
      single_read_value <= st_rd_data;
  end

  // ====================================================================
  // Register readback
  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_addr == `NVM_ADDR_KEY)
      next_rdata = unlock_key;
    else if (reg_addr == `NVM_ADDR_STATUS)
      next_rdata[`NVM_BIT_READY] = nvm_ready;
    else if (reg_addr == `NVM_ADDR_LOCATION)
      next_rdata[7:0] = single_access_location;
    else if (reg_addr == `NVM_ADDR_WDATA)
      next_rdata = single_write_value;
    else if (reg_addr == `NVM_ADDR_ACCESS)
    begin
      next_rdata[`NVM_BIT_SHADOW] = shadow_select;
      next_rdata[`NVM_BIT_RELOAD] = nvm_reload;
      next_rdata[`NVM_BIT_WEN] = nvm_write_enable;
      next_rdata[`NVM_MODE_HI:`NVM_MODE_LO] = mode;
    end
    else if (reg_addr == `NVM_ADDR_RDATA)
      next_rdata = single_read_value;
    else if (reg_addr == `NVM_ADDR_HALT)
      next_rdata = 16'h0000;
    else if (reg_addr == `NVM_ADDR_CFG_BASE)
      next_rdata = active_cfg;
    else
      next_rdata = 16'h0000;
  end

  // Read data register; held between reads.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (ce && reg_rd)
      reg_rdata <= next_rdata;
  end

  // Ready when the sequencer is idle and no cell write is running.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      nvm_ready <= 1'b0;
    else if (ce)
      nvm_ready <= (state == nvm_pkg::ST_IDLE) && !st_busy;
  end

  // ====================================================================
  // Configuration decode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      spread_spectrum_sel <= 2'h0;
      cycle_adjust_sel <= 1'b0;
      phase_resistance <= 11'h000;
    end
    else if (ce)
    begin
      spread_spectrum_sel <= active_cfg[`NVM_SSM_HI:`NVM_SSM_LO];
      cycle_adjust_sel <= active_cfg[`NVM_BIT_CYCADJ];
      phase_resistance <= 11'(active_cfg[`NVM_MANT_HI:`NVM_MANT_LO])
                          << active_cfg[`NVM_SHIFT_HI:`NVM_SHIFT_LO];
    end
  end

  // tach gate by loop state
  // Reserved code 11 keeps the tach quiet rather than guessing a mode.
  always_comb
  begin
    case (active_cfg[`NVM_TOL_HI:`NVM_TOL_LO])
      `NVM_TOL_ALWAYS: tach_gate = 1'b1;
      `NVM_TOL_CLOSED: tach_gate = closed_loop;
      `NVM_TOL_FIRST_OPEN: tach_gate = closed_loop || first_open_loop;
      default: tach_gate = 1'b0;
    endcase
  end

  // divide by n plus one
  // Two ticks per electrical cycle, toggling every n+1 ticks.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tach_cnt <= 4'h0;
      tach_phase <= 1'b0;
    end
    else if (ce && elec_tick)
    begin
      if (tach_cnt >= active_cfg[`NVM_DIV_HI:`NVM_DIV_LO])
      begin
        tach_cnt <= 4'h0;
        tach_phase <= ~tach_phase;
      end
      else
        tach_cnt <= tach_cnt + 4'h1;
    end
  end

  // Gated tach output, low while gated off.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tach_out <= 1'b0;
    else if (ce)
      tach_out <= tach_gate && tach_phase;
  end

endmodule : nvm_shadow_config_regs

/* File: bench/nvm_shadow_config_regs_chk.sv */
// Concurrent checks on the ports of the stored-configuration register block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps

module nvm_shadow_config_regs_chk (
  input wire logic core_clk, // Device clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ce, // Clock enable.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic motor_halt, // Motor control disabled.
  input wire logic [1:0] spread_spectrum_sel, // Dither select.
  input wire logic cycle_adjust_sel, // Cycle adjust select.
  input wire logic [10:0] phase_resistance, // Decoded resistance.
  input wire logic nvm_ready // Store ready.
);
  // ======================================================================
  // Clocking and sequences
  // Everything here lives in the one device clock domain.
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // A read strobe taken at a given address.
  sequence s_rd(logic [7:0] a);
    reg_rd && ce && reg_addr == a;
  endsequence

  // A write strobe taken at the halt register.
  sequence s_halt_wr;
    reg_wr && ce && reg_addr == 8'h60;
  endsequence

  // ======================================================================
  // Assertions
  a_halt_follow: assert property (s_halt_wr |=> motor_halt == $past(reg_wdata[15]))
    else $error("halt output does not follow the written bit");
  a_halt_hold: assert property (!(reg_wr && ce && reg_addr == 8'h60) |=> $stable(motor_halt))
    else $error("halt output changed without a write");
  a_halt_unread: assert property (s_rd(8'h60) |=> reg_rdata == 16'h0000)
    else $error("halt register read back nonzero");
  a_unused_zero: assert property (reg_rd && ce &&
    (reg_addr inside {[8'h37:8'h5f], [8'h61:8'h8f]}) |=> reg_rdata == 16'h0000)
    else $error("unused address read back nonzero");
  a_rdata_stands: assert property (!(reg_rd && ce) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_status_ready: assert property (s_rd(8'h32) |=> reg_rdata == {15'h0000, $past(nvm_ready)})
    else $error("status read does not show the ready flag");
  a_field_decode: assert property (s_rd(8'h90) |=>
    reg_rdata[15:14] == spread_spectrum_sel && reg_rdata[7] == cycle_adjust_sel)
    else $error("dither or cycle adjust output differs from the active word");
  a_resist_form: assert property (s_rd(8'h90) |=>
    phase_resistance == (11'(reg_rdata[3:0]) << reg_rdata[6:4]))
    else $error("resistance output is not mantissa shifted by shift");
endmodule : nvm_shadow_config_regs_chk

/* File: bench/reg_host_model.sv */
// Host side of the register strobe bus, standing in for the serial host.
// Assumes one transfer at a time, started by the bench through its tasks.
`timescale 1ns/100ps

module reg_host_model (
  input wire logic core_clk, // Device clock.
  input wire logic [15:0] reg_rdata, // Read data from the device.
  output logic [7:0] reg_addr, // Register address.
  output logic [15:0] reg_wdata, // Register write data.
  output logic reg_wr, // Write strobe.
  output logic reg_rd // Read strobe.
);
  // ======================================================================
  // Idle bus
  // Strobes start low so nothing is taken during reset.
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ======================================================================
  // Transfers
  // no reserved writes: callers pass whole words; the bench breaks this on purpose.
  // One write strobe, held for exactly the edge that takes it.
  // Returns half a cycle later so callers see the registers it updated.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask : wr

  // One read strobe; the data is picked up once it has settled.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : reg_host_model

/* File: bench/nvm_shadow_config_regs_tb_top.sv */
// Self-checking bench for the stored-configuration register block.
// Assumes the host model drives the register strobes and the checker is bound.
`timescale 1ns/100ps

module nvm_shadow_config_regs_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic elec_tick = 1'b0;
  logic closed_loop = 1'b0;
  logic first_open_loop = 1'b0;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic tach_out;
  logic motor_halt;
  logic [1:0] spread_spectrum_sel;
  logic cycle_adjust_sel;
  logic [10:0] phase_resistance;
  logic nvm_ready;
  logic [15:0] w;
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] zero_addr [6] = '{8'h31, 8'h33, 8'h34, 8'h35, 8'h36, 8'h90};
  logic [7:0] gap_addr [4] = '{8'h37, 8'h5f, 8'h61, 8'h8f};
  // Rows are gate code, closed loop, first open loop, expected tach level.
  logic [4:0] gate_row [5] = '{5'b01000, 5'b01101, 5'b10011, 5'b10000, 5'b11110};

  // ======================================================================
  // Instances
  // A short store write keeps the run brief.
  nvm_shadow_config_regs #(.WRITE_CYCLES(1)) nvm_shadow_config_regs_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .elec_tick(elec_tick),
    .closed_loop(closed_loop), .first_open_loop(first_open_loop), .tach_out(tach_out),
    .motor_halt(motor_halt), .spread_spectrum_sel(spread_spectrum_sel),
    .cycle_adjust_sel(cycle_adjust_sel), .phase_resistance(phase_resistance),
    .nvm_ready(nvm_ready));
  reg_host_model reg_host_model_i (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // Free-running device clock.
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ======================================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    reg_host_model_i.rd(a, d);
    chk($sformatf("register %h", a), d, exp);
  endtask : rchk

  // Polls the status register under a bound, since store timing is not fixed.
  task automatic wait_ready;
    logic [15:0] d;
    int n;
    n = 0;
    d = 16'h0000;
    while (d !== 16'h0001 && n < 50)
    begin
      reg_host_model_i.rd(8'h32, d);
      n++;
    end
    chk("ready flag", d, 16'h0001);
    chk("ready pin", 16'(nvm_ready), 16'h0001);
  endtask : wait_ready

  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ======================================================================
  // Tests
  // One sequence of register calls; later steps rely on earlier state.
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    foreach (zero_addr[i]) rchk(zero_addr[i], 16'h0000);
    rchk(8'h32, 16'h0001);
    foreach (gap_addr[i])
    begin
      reg_host_model_i.wr(gap_addr[i], 16'hffff);
      rchk(gap_addr[i], 16'h0000);
    end
    chk("halt after gaps", 16'(motor_halt), 16'h0000);
    reg_host_model_i.wr(8'h60, 16'h8000);
    chk("halt set", 16'(motor_halt), 16'h0001);
    rchk(8'h60, 16'h0000);
    // Reserved bits and triggers written without a key must not stick.
    reg_host_model_i.wr(8'h35, 16'hfffd);
    rchk(8'h35, 16'h1001);
    rchk(8'h32, 16'h0001);
    // host-encoded words: mantissa top bit set whenever shift is nonzero.
    for (int i = 0; i < 4; i++)
    begin
      w = {2'(i), 6'h00, 1'(i), 3'(2 * i + 1), 4'(12 + i)};
      reg_host_model_i.wr(8'h90, w);
      rchk(8'h90, w);
      chk("dither", 16'(spread_spectrum_sel), 16'(i));
      chk("cycle adjust", 16'(cycle_adjust_sel), 16'(i % 2));
      chk("resistance", 16'(phase_resistance), 16'((12 + i) << (2 * i + 1)));
    end
    // halt is still set from above while the store is programmed.
    reg_host_model_i.wr(8'h31, 16'hc0de);
    reg_host_model_i.wr(8'h33, 16'h0090);
    reg_host_model_i.wr(8'h34, 16'ha5c3);
    reg_host_model_i.wr(8'h35, 16'h1005);
    wait_ready();
    rchk(8'h35, 16'h1001);
    rchk(8'h36, 16'ha5c3);
    rchk(8'h90, w);
    reg_host_model_i.wr(8'h35, 16'h0001);
    rchk(8'h90, 16'ha5c3);
    reg_host_model_i.wr(8'h35, 16'h0101);
    wait_ready();
    reg_host_model_i.wr(8'h35, 16'h1001);
    rchk(8'h90, 16'ha5c3);
    reg_host_model_i.wr(8'h90, 16'h5a3c);
    reg_host_model_i.wr(8'h35, 16'h1002);
    reg_host_model_i.wr(8'h35, 16'h1006);
    rchk(8'h32, 16'h0000);
    wait_ready();
    reg_host_model_i.wr(8'h35, 16'h0002);
    rchk(8'h90, 16'h5a3c);
    // Mode off, then a wrong key: triggers must be dropped.
    reg_host_model_i.wr(8'h35, 16'h0000);
    reg_host_model_i.wr(8'h35, 16'h0104);
    rchk(8'h35, 16'h0000);
    reg_host_model_i.wr(8'h31, 16'h0000);
    reg_host_model_i.wr(8'h35, 16'h0001);
    reg_host_model_i.wr(8'h35, 16'h0005);
    rchk(8'h35, 16'h0001);
    rchk(8'h90, 16'h5a3c);
    reg_host_model_i.wr(8'h60, 16'h0000);
    chk("halt clear", 16'(motor_halt), 16'h0000);
    // With the clock enable low a write must leave all state frozen.
    @(posedge core_clk);
    ce <= 1'b0;
    reg_host_model_i.wr(8'h60, 16'h8000);
    chk("halt frozen", 16'(motor_halt), 16'h0000);
    @(posedge core_clk);
    ce <= 1'b1;
    // Tach with divider 2 from the shadow word, gate code 00.
    reg_host_model_i.wr(8'h35, 16'h1000);
    reg_host_model_i.wr(8'h90, 16'h0200);
    for (int i = 1; i < 10; i++)
    begin
      @(posedge core_clk);
      elec_tick <= 1'b1;
      @(posedge core_clk);
      elec_tick <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("tach divide", 16'(tach_out), 16'((i / 3) % 2));
    end
    foreach (gate_row[i])
    begin
      closed_loop <= gate_row[i][2];
      first_open_loop <= gate_row[i][1];
      reg_host_model_i.wr(8'h90, {2'h0, gate_row[i][4:3], 12'h200});
      repeat (3) @(posedge core_clk);
      chk("tach gate", 16'(tach_out), 16'(gate_row[i][0]));
    end
    stop_test();
  end

  // Cuts a hang short well beyond the expected few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    stop_test();
  end
endmodule : nvm_shadow_config_regs_tb_top

bind nvm_shadow_config_regs nvm_shadow_config_regs_chk nvm_shadow_config_regs_chk_i (
  .core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_halt(motor_halt),
  .spread_spectrum_sel(spread_spectrum_sel), .cycle_adjust_sel(cycle_adjust_sel),
  .phase_resistance(phase_resistance), .nvm_ready(nvm_ready));
